// file: mmta_cfg.svh
// Constants for the five-channel general timer group.
// Assumes a single 100 MHz core clock; included by bare name.
`ifndef MMTA_CFG_SVH
`define MMTA_CFG_SVH
`define MMTA_NUM_TIMERS     5
`define MMTA_CNT_W          16
`define MMTA_MODE_W         2
`define MMTA_MODE_TIMER     2'h0
`define MMTA_MODE_EVENT     2'h1
`define MMTA_MODE_ONESHOT   2'h2
`define MMTA_MODE_PWM       2'h3
`define MMTA_SRC_DIV1       2'h0
`define MMTA_SRC_DIV8       2'h1
`define MMTA_SRC_DIV32      2'h2
`define MMTA_SRC_SUB32      2'h3
`define MMTA_DIV8_TOP       5'h07
`define MMTA_DIV32_TOP      5'h1F
`define MMTA_SUB_DIV_DEF    16'h0BEB
`define MMTA_TWO_PHASE_MIN  2
`define MMTA_RESET_COUNT    16'h0000
`define MMTA_GATE_HIGH      1'h1
`endif

// file: mmta_chan.sv
// One 16-bit general timer channel.
// Assumes prescale enables and synchronised pins from the parent.
`include "mmta_cfg.svh"
module mmta_chan #(
  parameter int IDX = 0
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire mmta_pkg::mmta_ctrl_t ctrl,
  input  wire mmta_pkg::mmta_wr_t   wr,
  input  wire logic [3:0]          src_en,
  input  wire logic                gate_level,
  input  wire logic                phase_b,
  input  wire logic                ovf_in,
  output logic [15:0]              count,
  output logic                     irq,
  output logic                     ovf,
  output logic                     pulse_out
);
  logic [15:0] reload;
  logic        gate_d;
  logic        gate_rise;
  logic        tick;
  logic        down;
  logic        running;
  logic        oneshot_done;
  logic        wrap;

  assign gate_rise = gate_level & ~gate_d;
  assign running   = ctrl.count_start && !oneshot_done;

  always_comb begin
    tick = 1'b0;
    down = 1'b1;
    case (ctrl.mode)
      mmta_pkg::MMTA_EVENT: begin
        tick = gate_rise | ovf_in;
        if (ctrl.two_phase && IDX >= `MMTA_TWO_PHASE_MIN) begin
          tick = gate_rise;
          down = phase_b;
        end
      end
      mmta_pkg::MMTA_TIMER,
      mmta_pkg::MMTA_ONESHOT,
      mmta_pkg::MMTA_PWM: begin
        tick = src_en[ctrl.src_sel];
        if (ctrl.gate_en && gate_level != `MMTA_GATE_HIGH) begin
          tick = 1'b0;
        end
      end
      default: tick = 1'b0;
    endcase
    tick = tick & running;
  end

  // Underflow is a decrement from zero, overflow an increment from all ones
  assign wrap = tick && (down ? (count == 16'h0000) : (count == 16'hFFFF));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gate_d <= 1'b0;
    end else begin
      gate_d <= gate_level;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reload <= `MMTA_RESET_COUNT;
    end else if (wr.wr) begin
      reload <= wr.data;
    end
  end

  // Counter: a stopped write lands at once; a running write waits for reload
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= `MMTA_RESET_COUNT;
    end else if (wr.wr && !running) begin
      count <= wr.data;
    end else if (wrap) begin
      count <= reload;
    end else if (tick) begin
      count <= down ? count - 16'h0001 : count + 16'h0001;
    end
  end

  // One-shot stops at zero; rearmed by clearing the start flag
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      oneshot_done <= 1'b0;
    end else if (!ctrl.count_start || ctrl.mode != mmta_pkg::MMTA_ONESHOT) begin
      oneshot_done <= 1'b0;
    end else if (tick && count == 16'h0001) begin
      oneshot_done <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
      ovf <= 1'b0;
    end else begin
      irq <= wrap;
      ovf <= wrap;
    end
  end

  // PWM reuses the toggle; width set by reload value
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pulse_out <= 1'b0;
    end else if (wrap && (ctrl.pulse_en || ctrl.mode == mmta_pkg::MMTA_PWM)) begin
      pulse_out <= ~pulse_out;
    end
  end
endmodule

// file: mmta_pin_model.sv
// Far side of the timer pins: gate level and pulse watcher.
// Assumes the bench sets ext_gate just after a clock edge.
module mmta_pin_model #(
  parameter int NUM = 5
) (
  input  wire logic           core_clk,
  input  wire logic [NUM-1:0] ext_gate,
  input  wire logic [NUM-1:0] pin_oe,
  input  wire logic [NUM-1:0] pin_out,
  input  wire logic [NUM-1:0] pulse_pin,
  output logic [NUM-1:0]      gate_wire,
  output int                  toggles
);
  logic last = 1'b0;
  int   seen = 0;
  // Device drive wins the wire while enabled
  assign gate_wire = (pin_oe & pin_out) | (~pin_oe & ext_gate);
  assign toggles   = seen;
  always @(posedge core_clk) begin
    if (pulse_pin[0] !== last) seen++;
    last = pulse_pin[0];
  end
endmodule

// file: mmta_pkg.sv
// Types shared by the timer group.
// Assumes mmta_cfg.svh is compiled alongside.
`include "mmta_cfg.svh"
package mmta_pkg;
  typedef enum logic [1:0] {
    MMTA_TIMER   = 2'h0,
    MMTA_EVENT   = 2'h1,
    MMTA_ONESHOT = 2'h2,
    MMTA_PWM     = 2'h3
  } mmta_mode_t;

  typedef struct packed {
    mmta_mode_t  mode;
    logic [1:0]  src_sel;
    logic        gate_en;
    logic        pulse_en;
    logic        two_phase;
    logic        count_start;
  } mmta_ctrl_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } mmta_wr_t;
endpackage

// file: mmta_sync.sv
// Three-stage pin synchroniser.
// Assumes an asynchronous input; output changes once stages two and three agree.
module mmta_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule

// file: mmta_top.sv
// Top of the five-channel general timer group.
// Assumes a 100 MHz core clock and software-side control ports.
`include "mmta_cfg.svh"
module mmta_top #(
  parameter int          NUM     = `MMTA_NUM_TIMERS,
  parameter logic [15:0] SUB_DIV = `MMTA_SUB_DIV_DEF
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic [NUM-1:0][1:0]      mode_sel,
  input  wire logic [NUM-1:0][1:0]      src_sel,
  input  wire logic [NUM-1:0]           gate_en,
  input  wire logic [NUM-1:0]           pulse_en,
  input  wire logic [NUM-1:0]           two_phase,
  input  wire logic [NUM-1:0]           count_start,
  input  wire logic [NUM-1:0]           timer_wr,
  input  wire logic [15:0]              timer_wdata,
  output logic [NUM-1:0][15:0]          timer_rdata,
  output logic [NUM-1:0]                timer_irq,
  input  wire logic [NUM-1:0]           timer_gate_input_pin,
  input  wire logic [NUM-1:0]           phase_b_pin,
  input  wire logic [NUM-1:0]           port_in_oe,
  input  wire logic [NUM-1:0]           port_in_out,
  output logic [NUM-1:0]                gate_pin_out,
  output logic [NUM-1:0]                gate_pin_oe,
  input  wire logic [NUM-1:0]           port_out_data,
  output logic [NUM-1:0]                timer_pulse_output_pin,
  output logic [NUM-1:0]                port_in_level
);
  logic [4:0]     pre_cnt;
  logic [15:0]    sub_cnt;
  logic [4:0]     sub_pre;
  logic           prescaled_clock_div_one;
  logic           prescaled_clock_div_eight;
  logic           prescaled_clock_div_thirtytwo;
  logic           subclock_div_thirtytwo;
  logic           sub_tick;
  logic [3:0]     src_en;
  logic [NUM-1:0] gate_lvl;
  logic [NUM-1:0] phb_lvl;
  logic [NUM-1:0] ovf;
  logic [NUM-1:0] pulse;

  // Shared prescaler; one enable per source keeps a single clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pre_cnt <= 5'h00;
    end else begin
      pre_cnt <= pre_cnt + 5'h01;
    end
  end

  // Subclock stand-in derived from the core clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sub_cnt <= 16'h0000;
    end else if (sub_tick) begin
      sub_cnt <= 16'h0000;
    end else begin
      sub_cnt <= sub_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sub_pre <= 5'h00;
    end else if (sub_tick) begin
      sub_pre <= sub_pre + 5'h01;
    end
  end

  assign sub_tick                      = (sub_cnt == SUB_DIV);
  assign prescaled_clock_div_one       = 1'b1;
  assign prescaled_clock_div_eight     = (pre_cnt[2:0] == 3'(`MMTA_DIV8_TOP));
  assign prescaled_clock_div_thirtytwo = (pre_cnt == `MMTA_DIV32_TOP);
  assign subclock_div_thirtytwo        = sub_tick && (sub_pre == `MMTA_DIV32_TOP);
  assign src_en = {subclock_div_thirtytwo, prescaled_clock_div_thirtytwo,
                   prescaled_clock_div_eight, prescaled_clock_div_one};

  genvar gi;
  generate
    for (gi = 0; gi < NUM; gi++) begin : g_ch
      mmta_pkg::mmta_ctrl_t ctrl;
      mmta_pkg::mmta_wr_t   wr;

      always_comb begin
        ctrl.mode        = mmta_pkg::mmta_mode_t'(mode_sel[gi]);
        ctrl.src_sel     = src_sel[gi];
        ctrl.gate_en     = gate_en[gi] && !port_in_oe[gi];
        ctrl.pulse_en    = pulse_en[gi];
        ctrl.two_phase   = two_phase[gi];
        ctrl.count_start = count_start[gi];
        wr.wr            = timer_wr[gi];
        wr.data          = timer_wdata;
      end

      mmta_sync u_gate (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin      (timer_gate_input_pin[gi]),
        .level    (gate_lvl[gi])
      );

      mmta_sync u_phb (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin      (phase_b_pin[gi]),
        .level    (phb_lvl[gi])
      );

      // Same channel logic; two-phase only from channel 2 up, event mode chained to the previous channel's overflow
      mmta_chan #(
        .IDX (gi)
      ) u_chan (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .ctrl       (ctrl),
        .wr         (wr),
        .src_en     (src_en),
        .gate_level (gate_lvl[gi]),
        .phase_b    (phb_lvl[gi]),
        .ovf_in     (ovf[(gi + NUM - 1) % NUM]),
        .count      (timer_rdata[gi]),
        .irq        (timer_irq[gi]),
        .ovf        (ovf[gi]),
        .pulse_out  (pulse[gi])
      );
    end
  endgenerate

  // Pin muxing: port function unless gate or pulse chosen
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gate_pin_out <= '0;
      gate_pin_oe  <= '0;
    end else begin
      gate_pin_out <= port_in_out;
      gate_pin_oe  <= port_in_oe & ~gate_en;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      port_in_level <= '0;
    end else begin
      port_in_level <= gate_lvl;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timer_pulse_output_pin <= '0;
    end else begin
      for (int i = 0; i < NUM; i++) begin
        timer_pulse_output_pin[i] <= pulse_en[i] ? pulse[i] : port_out_data[i];
      end
    end
  end
endmodule

// file: mmta_top_asserts.sv
// Checker for the timer group top, channel 0 watched.
// Assumes a bind onto mmta_top; pins resolved by the bench.
module mmta_top_asserts #(
  parameter int NUM = 5
) (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic [NUM-1:0][1:0] mode_sel,
  input wire logic [NUM-1:0][1:0] src_sel,
  input wire logic [NUM-1:0]      gate_en,
  input wire logic [NUM-1:0]      pulse_en,
  input wire logic [NUM-1:0]      count_start,
  input wire logic [NUM-1:0]      timer_wr,
  input wire logic [15:0]         timer_wdata,
  input wire logic [NUM-1:0][15:0] timer_rdata,
  input wire logic [NUM-1:0]      timer_irq,
  input wire logic [NUM-1:0]      timer_gate_input_pin,
  input wire logic [NUM-1:0]      port_out_data,
  input wire logic [NUM-1:0]      timer_pulse_output_pin
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] reload;
  always_ff @(posedge core_clk) begin
    if (!rst_n) reload <= 16'h0000;
    else if (timer_wr[0]) reload <= timer_wdata;
  end
  sequence s_go;
    (count_start[0] && mode_sel[0] == 2'h0 && src_sel[0] == 2'h0 && !gate_en[0])[*3];
  endsequence
  // No write for three cycles, so the reload copy is settled
  sequence s_calm;
    (count_start[0] && mode_sel[0] == 2'h0 && src_sel[0] == 2'h0 && !gate_en[0] && !timer_wr[0])[*3];
  endsequence
  AST_STOP_WRITE: assert property (!count_start[0] && timer_wr[0] |=> timer_rdata[0] == $past(timer_wdata))
    else $error("stopped write not loaded");
  AST_RUN_WRITE: assert property (s_go ##0 timer_wr[0] && timer_rdata[0] > 16'h0002
    |=> timer_rdata[0] == $past(timer_rdata[0]) - 16'h0001)
    else $error("running write touched counter");
  AST_DECR: assert property (s_calm ##0 timer_rdata[0] != 16'h0000
    |=> timer_rdata[0] == $past(timer_rdata[0]) - 16'h0001)
    else $error("count not down by one");
  AST_RELOAD: assert property (s_calm ##0 timer_rdata[0] == 16'h0000 |=> timer_rdata[0] == reload)
    else $error("no reload on underflow");
  AST_IRQ: assert property (s_calm ##0 timer_rdata[0] == 16'h0000 |-> ##[0:2] timer_irq[0])
    else $error("no request on underflow");
  AST_STOPPED: assert property ((!count_start[0] && !timer_wr[0])[*3] |-> $stable(timer_rdata[0]) && !timer_irq[0])
    else $error("counting while stopped");
  AST_PULSE: assert property (pulse_en[0] [*3] ##0 timer_irq[0] |-> ##[0:2] $changed(timer_pulse_output_pin[0]))
    else $error("pulse pin did not toggle");
  AST_PORT_OUT: assert property (!pulse_en[0] ##1 !pulse_en[0] && $past(rst_n)
    |-> timer_pulse_output_pin[0] == $past(port_out_data[0]))
    else $error("output pin not port value");
  AST_GATE: assert property ((mode_sel[0] == 2'h0 && gate_en[0] && !timer_gate_input_pin[0] && !timer_wr[0])[*8]
    |-> $stable(timer_rdata[0]))
    else $error("counting with gate low");
endmodule

// file: tb.sv
// Self-checking bench for the timer group, channel 0 in depth.
// Assumes the pin model and checker are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NUM = 5;
  logic                 core_clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic [NUM-1:0][1:0]  mode_sel = '0;
  logic [NUM-1:0][1:0]  src_sel = '0;
  logic [NUM-1:0]       gate_en = '0, pulse_en = '0, count_start = '0, timer_wr = '0;
  logic [NUM-1:0]       port_in_oe = '0, port_in_out = '0, port_out_data = '0, ext_gate = '0;
  logic [NUM-1:0]       two_phase = '0, phase_b = '0;
  logic [15:0]          timer_wdata = 16'h0000;
  logic [NUM-1:0][15:0] timer_rdata;
  logic [NUM-1:0]       timer_irq, gate_pin_out, gate_pin_oe, pulse_pin, in_level, gate_wire;
  int                   toggles, errors = 0, total_checks = 0, cycles = 0, irqs = 0, a, t;
  int                   per[4] = '{1, 8, 32, 96};
  always #5 core_clk = ~core_clk;
  mmta_top #(.NUM(NUM), .SUB_DIV(16'h0002)) dut (.core_clk(core_clk), .rst_n(rst_n), .mode_sel(mode_sel),
    .src_sel(src_sel), .gate_en(gate_en), .pulse_en(pulse_en), .two_phase(two_phase), .count_start(count_start),
    .timer_wr(timer_wr), .timer_wdata(timer_wdata), .timer_rdata(timer_rdata), .timer_irq(timer_irq),
    .timer_gate_input_pin(gate_wire), .phase_b_pin(phase_b), .port_in_oe(port_in_oe), .port_in_out(port_in_out),
    .gate_pin_out(gate_pin_out), .gate_pin_oe(gate_pin_oe), .port_out_data(port_out_data),
    .timer_pulse_output_pin(pulse_pin), .port_in_level(in_level));
  mmta_pin_model #(.NUM(NUM)) pins (.core_clk(core_clk), .ext_gate(ext_gate), .pin_oe(gate_pin_oe),
    .pin_out(gate_pin_out), .pulse_pin(pulse_pin), .gate_wire(gate_wire), .toggles(toggles));
  // Ceiling well above the roughly 940 cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (timer_irq[0] === 1'b1) irqs++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check_v(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_n(string what, int exp, int got);
    total_checks++;
    if (got != exp) begin
      errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [NUM-1:0] m, logic [15:0] d);
    timer_wr = m;
    timer_wdata = d;
    step(1);
    timer_wr = '0;
    step(2);
  endtask
  // Counts requests and toggles over a window of n cycles
  task automatic window(int n);
    a = irqs;
    t = toggles;
    step(n);
    a = irqs - a;
    t = toggles - t;
  endtask
  initial begin
    step(8);
    rst_n = 1'b1;
    step(1);
    check_v("reset count", 16'h0000, timer_rdata[0]);
    wr('1, 16'h0003);
    for (int i = 0; i < NUM; i++) check_v("stopped write", 16'h0003, timer_rdata[i]);
    pulse_en = '1;
    count_start = '1;
    step(20);
    for (int i = 0; i < NUM; i++) check_v("same count", 16'h0003, timer_rdata[i]);
    window(16);
    check_n("requests n=3", 4, a);
    check_n("toggles", 4, t);
    wr(5'h01, 16'h0005);
    check_v("running write", 16'h0000, timer_rdata[0]);
    step(20);
    window(18);
    check_n("requests n=5", 3, a);
    count_start = '0;
    step(3);
    check_v("stopped", 16'h0004, timer_rdata[0]);
    step(10);
    check_v("stopped", 16'h0004, timer_rdata[0]);
    pulse_en = '0;
    port_out_data = 5'h01;
    step(2);
    check_v("port out", 16'h0001, {15'h0000, pulse_pin[0]});
    for (int s = 0; s < 4; s++) begin
      src_sel[0] = s[1:0];
      wr(5'h01, 16'h0000);
      count_start[0] = 1'b1;
      step(100);
      window(per[s] * 2);
      check_n("source rate", 2, a);
      count_start[0] = 1'b0;
      step(3);
    end
    src_sel[0] = 2'h0;
    wr(5'h01, 16'h0003);
    gate_en[0] = 1'b1;
    count_start[0] = 1'b1;
    step(12);
    window(16);
    check_n("gate low", 0, a);
    ext_gate[0] = 1'b1;
    step(12);
    window(16);
    check_n("gate high", 4, a);
    count_start[0] = 1'b0;
    gate_en[0] = 1'b0;
    port_in_oe[0] = 1'b1;
    port_in_out[0] = 1'b1;
    step(2);
    check_v("port drive", 16'h0001, {15'h0000, gate_pin_oe[0]});
    check_v("port value", 16'h0001, {15'h0000, gate_pin_out[0]});
    // Gate enable must release the port drive, while port_in_oe still masks the channel gate
    gate_en[0] = 1'b1;
    step(2);
    check_v("gate no drive", 16'h0000, {15'h0000, gate_pin_oe[0]});
    gate_en[0] = 1'b0;
    mode_sel[0] = 2'h2;
    wr(5'h01, 16'h0004);
    count_start[0] = 1'b1;
    step(20);
    check_v("one-shot end", 16'h0000, timer_rdata[0]);
    // Event mode: channel 0 single-phase only, channel 2 honours two-phase
    mode_sel[0] = 2'h1;
    mode_sel[2] = 2'h1;
    two_phase = 5'h05;
    count_start = '0;
    port_in_oe[0] = 1'b0;
    port_in_out[0] = 1'b0;
    ext_gate = '0;
    wr(5'h05, 16'h0002);
    count_start = 5'h05;
    a = irqs;
    for (int p = 0; p < 3; p++) begin
      phase_b[2] = (p == 2);
      ext_gate = 5'h05;
      step(8);
      check_v("input level", 16'h0001, {15'h0000, in_level[0]});
      ext_gate = '0;
      step(8);
      check_v("event count", 16'((4 - p) % 3), timer_rdata[0]);
      check_v("two-phase count", (p == 2) ? 16'h0003 : 16'(3 + p), timer_rdata[2]);
    end
    check_n("event wraps", 1, irqs - a);
    stop_test();
  end
endmodule
bind mmta_top mmta_top_asserts #(.NUM(NUM)) chk (.core_clk, .rst_n, .mode_sel, .src_sel, .gate_en, .pulse_en,
  .count_start, .timer_wr, .timer_wdata, .timer_rdata, .timer_irq, .timer_gate_input_pin, .port_out_data,
  .timer_pulse_output_pin);
